// ### src/ces_edge_shaper.sv
// Carrier edge shaper with its settings registers on an Avalon-MM slave
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ces_edge_shaper #(
  parameter logic [7:0] CARRIER_DIV = ces_pkg::CARRIER_DIV_DEF
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [8:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic mod_pause,
  input wire logic [7:0] amplifier_supply_voltage,
  output logic [7:0] carrier_amp,
  output logic shaping_busy
);

  ces_pkg::ces_s r;
  ces_pkg::ces_s next_r;
  logic tick;
  logic [7:0] rd;
  logic [7:0] widx;

  // Fraction of the edge reached after transition state k of n, 0 to FF
  function automatic logic [7:0] edge_frac(input logic [3:0] kind, input logic [2:0] sel,
      input logic [4:0] k, input logic [4:0] n, input logic [7:0] vdd);
    logic [12:0] lin;
    logic [7:0] f;
    logic [2:0] idx;
    logic [15:0] prod;
    lin = ((13'(k) + 13'h1) * 13'h0FF) / 13'(n);
    f = lin[7:0];
    idx = 3'((8'(k) << 3) / 8'(n));
    prod = 16'h0000;
    case (kind)
      ces_pkg::KIND_LIN1: f = f;
      ces_pkg::KIND_LIN2: begin
        f = (f < 8'h80) ? f + (f >> 1) : 8'hC0 + ((f - 8'h80) >> 1);
      end
      ces_pkg::KIND_LIN3: begin
        if (f < 8'h55) begin
          f = f << 1;
        end else if (f < 8'hAA) begin
          f = 8'hAA + ((f - 8'h55) >> 1);
        end else begin
          f = 8'hD4 + ((f - 8'hAA) >> 1);
        end
      end
      ces_pkg::KIND_LUT, ces_pkg::KIND_LUT_ADJ_COR, ces_pkg::KIND_LUT_ADJ: begin
        f = ces_pkg::EDGE_LUT[{sel[1:0], idx, 3'h0} +: 8];
        if (kind != ces_pkg::KIND_LUT) begin
          // A weaker supply pulls the edge forward to keep its shape
          prod = 16'(8'hFF - f) * 16'(8'hFF - vdd);
          f = f + prod[15:8];
        end
        if (kind == ces_pkg::KIND_LUT_ADJ_COR) begin
          f = f - (f >> 4);
        end
      end
      default: f = 8'h00; // Reserved codes leave the level where it is
    endcase
    // Firmware styles: the style field speeds the start of the edge
    if (kind >= ces_pkg::KIND_LIN1 && kind <= ces_pkg::KIND_LIN3) begin
      f = f + ((8'hFF - f) >> (4'h8 - {1'b0, sel}));
    end
    // For edge type codes 1 to 6 the last state lands exactly on the target level, so the edge ends cleanly
    if (k == n - 5'h01 && kind >= ces_pkg::KIND_LIN1 && kind <= ces_pkg::KIND_LUT_ADJ) begin
      f = 8'hFF;
    end
    return f;
  endfunction

  // Level between two amplitudes at the given edge fraction
  function automatic logic [7:0] interp(input logic [7:0] from, input logic [7:0] to,
      input logic [7:0] f);
    logic [15:0] prod;
    if (to >= from) begin
      prod = 16'(to - from) * 16'(f);
      return from + 8'(prod / 16'h00FF);
    end else begin
      prod = 16'(from - to) * 16'(f);
      return from - 8'(prod / 16'h00FF);
    end
  endfunction

  assign tick = (r.div == CARRIER_DIV - 8'h01);
  assign widx = 8'(avs_address >> 2);

  // Register read multiplexer
  always_comb begin
    rd = 8'h00;
    case (widx)
      ces_pkg::IDX_KIND_106: rd = r.kind106;
      ces_pkg::IDX_STYLE_106: rd = r.style;
      ces_pkg::IDX_LENGTH_106: rd = r.length;
      ces_pkg::IDX_RESID_212: rd = r.resid;
      ces_pkg::IDX_KIND_212: rd = r.kind212;
      ces_pkg::IDX_CTRL: rd = {7'h00, r.prof};
      default: rd = 8'h00;
    endcase
  end

  // Next state of bus slave, settings, synchroniser and shaper
  always_comb begin
    next_r = r;
    next_r.ack = 1'b0;
    next_r.wait_r = 1'b1;
    // Answer one cycle after the request is seen
    if ((avs_read || avs_write) && !r.ack) begin
      next_r.ack = 1'b1;
      next_r.wait_r = 1'b0;
      if (widx == ces_pkg::IDX_STATUS) begin
        next_r.rdata = {8'h00, r.amp, 3'h0, r.step, 6'h00, r.state};
      end else begin
        next_r.rdata = {24'h000000, rd};
      end
    end
    // Write lands at the edge where waitrequest is low
    if (r.ack && avs_write && avs_byteenable[0]) begin
      case (widx)
        ces_pkg::IDX_KIND_106: next_r.kind106 = avs_writedata[7:0];
        ces_pkg::IDX_STYLE_106: next_r.style = avs_writedata[7:0] & ces_pkg::STYLE_MASK;
        ces_pkg::IDX_LENGTH_106: next_r.length = avs_writedata[7:0] & ces_pkg::LENGTH_MASK;
        ces_pkg::IDX_RESID_212: next_r.resid = avs_writedata[7:0];
        ces_pkg::IDX_KIND_212: next_r.kind212 = avs_writedata[7:0];
        ces_pkg::IDX_CTRL: next_r.prof = avs_writedata[0];
        default: next_r.prof = r.prof;
      endcase
    end
    // Supply level comes from outside the clock domain
    next_r.vdd_s1 = amplifier_supply_voltage;
    next_r.vdd_s2 = r.vdd_s1;
    next_r.div = tick ? 8'h00 : r.div + 8'h01;
    unique case (r.state)
      ces_pkg::ST_IDLE: begin
        next_r.amp = ces_pkg::AMP_FULL;
        if (mod_pause) begin
          // Settings are frozen for the whole pause
          next_r.lat_fk = r.prof ? r.kind212[ces_pkg::FALL_HI:ces_pkg::FALL_LO]
                                 : r.kind106[ces_pkg::FALL_HI:ces_pkg::FALL_LO];
          next_r.lat_rk = r.prof ? r.kind212[ces_pkg::RISE_HI:ces_pkg::RISE_LO]
                                 : r.kind106[ces_pkg::RISE_HI:ces_pkg::RISE_LO];
          next_r.lat_fs = r.style[6:4];
          next_r.lat_rs = r.style[2:0];
          next_r.lat_n = r.length[ces_pkg::NUM_HI:0];
          next_r.lat_dbl = r.length[ces_pkg::DBL_BIT];
          next_r.lat_resid = r.resid;
          next_r.step = 5'h00;
          next_r.sub = 1'b0;
          if (next_r.lat_n == 5'h00) begin
            next_r.state = ces_pkg::ST_LOW;
            next_r.amp = r.resid;
          end else begin
            next_r.state = ces_pkg::ST_FALL;
            next_r.amp = interp(ces_pkg::AMP_FULL, r.resid, edge_frac(next_r.lat_fk,
                next_r.lat_fs, 5'h00, next_r.lat_n, r.vdd_s2));
          end
        end
      end
      ces_pkg::ST_FALL, ces_pkg::ST_RISE: begin
        if (tick) begin
          if (r.lat_dbl && !r.sub) begin
            next_r.sub = 1'b1;
          end else begin
            next_r.sub = 1'b0;
            if (r.step == r.lat_n - 5'h01) begin
              next_r.state = (r.state == ces_pkg::ST_FALL) ? ces_pkg::ST_LOW : ces_pkg::ST_IDLE;
              next_r.amp = (r.state == ces_pkg::ST_FALL) ? r.lat_resid : ces_pkg::AMP_FULL;
            end else begin
              next_r.step = r.step + 5'h01;
              if (r.state == ces_pkg::ST_FALL) begin
                next_r.amp = interp(ces_pkg::AMP_FULL, r.lat_resid, edge_frac(r.lat_fk,
                    r.lat_fs, next_r.step, r.lat_n, r.vdd_s2));
              end else begin
                next_r.amp = interp(r.lat_resid, ces_pkg::AMP_FULL, edge_frac(r.lat_rk,
                    r.lat_rs, next_r.step, r.lat_n, r.vdd_s2));
              end
            end
          end
        end
      end
      ces_pkg::ST_LOW: begin
        next_r.amp = r.lat_resid;
        if (!mod_pause) begin
          next_r.step = 5'h00;
          next_r.sub = 1'b0;
          if (r.lat_n == 5'h00) begin
            next_r.state = ces_pkg::ST_IDLE;
            next_r.amp = ces_pkg::AMP_FULL;
          end else begin
            next_r.state = ces_pkg::ST_RISE;
            next_r.amp = interp(r.lat_resid, ces_pkg::AMP_FULL, edge_frac(r.lat_rk,
                r.lat_rs, 5'h00, r.lat_n, r.vdd_s2));
          end
        end
      end
    endcase
    next_r.busy = (next_r.state != ces_pkg::ST_IDLE);
  end

  // State register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
      r.style <= ces_pkg::STYLE_RST;
      r.length <= ces_pkg::LENGTH_RST;
      r.resid <= ces_pkg::RESID_RST;
      r.kind212 <= ces_pkg::KIND_RST;
      r.kind106 <= ces_pkg::KIND_RST;
      r.state <= ces_pkg::ST_IDLE;
      r.amp <= ces_pkg::AMP_FULL;
      r.wait_r <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign avs_readdata = r.rdata;
  assign avs_waitrequest = r.wait_r;
  assign carrier_amp = r.amp;
  assign shaping_busy = r.busy;

  // Checks on reserved bits, timing, levels and the bus answer
  a_style_reserved_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
    !r.style[7] && !r.style[3])
    else $error("style register reserved bit set");
  a_length_reserved_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
    r.length[6:5] == 2'h0)
    else $error("length register reserved bit set");
  a_single_state_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    (r.state == ces_pkg::ST_FALL && tick && !r.lat_dbl && r.step != r.lat_n - 5'h01)
    |=> r.step == $past(r.step) + 5'h01)
    else $error("transition state did not end after one carrier cycle");
  a_double_state_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    (r.busy && r.state != ces_pkg::ST_LOW && tick && r.lat_dbl && !r.sub)
    |=> $stable(r.step) && r.sub && $stable(r.state))
    else $error("doubled transition state ended early");
  a_fall_state_count: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(r.state == ces_pkg::ST_LOW) && r.lat_n != 5'h00 |-> $past(r.step) == r.lat_n - 5'h01)
    else $error("falling edge used wrong number of states");
  a_residual_level: assert property (@(posedge ref_clk) disable iff (!nrst)
    r.state == ces_pkg::ST_LOW |-> r.amp == r.lat_resid)
    else $error("pause level differs from residual amplitude");
  a_settings_frozen: assert property (@(posedge ref_clk) disable iff (!nrst)
    r.busy && next_r.busy |=> $stable(r.lat_fk) && $stable(r.lat_n) && $stable(r.lat_resid))
    else $error("settings changed inside a pause");
  a_idle_full_level: assert property (@(posedge ref_clk) disable iff (!nrst)
    r.state == ces_pkg::ST_IDLE |-> r.amp == ces_pkg::AMP_FULL && !shaping_busy)
    else $error("idle carrier not at full amplitude");
  a_bus_answer_once: assert property (@(posedge ref_clk) disable iff (!nrst)
    (avs_read || avs_write) && !r.ack |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not a single cycle after request");

  // Checks on settings capture at pause start, rise timing, divider and register writes
  a_settings_captured: assert property (@(posedge ref_clk) disable iff (!nrst)
    r.state == ces_pkg::ST_IDLE && mod_pause
    |=> {r.lat_dbl, 2'h0, r.lat_n} == $past(r.length) && r.lat_resid == $past(r.resid))
    else $error("pause settings not taken from the registers");
  a_style_captured: assert property (@(posedge ref_clk) disable iff (!nrst)
    r.state == ces_pkg::ST_IDLE && mod_pause
    |=> {1'b0, r.lat_fs, 1'b0, r.lat_rs} == $past(r.style))
    else $error("edge style fields not taken from the style register");
  a_kind_captured: assert property (@(posedge ref_clk) disable iff (!nrst)
    r.state == ces_pkg::ST_IDLE && mod_pause
    |=> {r.lat_fk, r.lat_rk} == ($past(r.prof) ? $past(r.kind212) : $past(r.kind106)))
    else $error("edge type nibbles not taken from the selected register");
  a_single_rise_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    (r.state == ces_pkg::ST_RISE && tick && !r.lat_dbl && r.step != r.lat_n - 5'h01)
    |=> r.step == $past(r.step) + 5'h01)
    else $error("rising transition state did not end after one carrier cycle");
  a_rise_state_count: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(r.state == ces_pkg::ST_IDLE) && r.lat_n != 5'h00 |-> $past(r.step) == r.lat_n - 5'h01)
    else $error("rising edge used wrong number of states");
  a_carrier_divider: assert property (@(posedge ref_clk) disable iff (!nrst)
    r.div < CARRIER_DIV)
    else $error("carrier divider out of range");
  a_write_lands: assert property (@(posedge ref_clk) disable iff (!nrst)
    r.ack && avs_write && avs_byteenable[0] && widx == ces_pkg::IDX_RESID_212
    |=> r.resid == 8'($past(avs_writedata)))
    else $error("residual write did not land");

endmodule
`default_nettype wire

// ### src/ces_pkg.sv
// Constants, register map and state types for the carrier edge shaping block
package ces_pkg;
  // Printed register indices; byte address is four times the index
  localparam logic [7:0] IDX_KIND_106 = 8'h55;
  localparam logic [7:0] IDX_STYLE_106 = 8'h56;
  localparam logic [7:0] IDX_LENGTH_106 = 8'h57;
  localparam logic [7:0] IDX_RESID_212 = 8'h58;
  localparam logic [7:0] IDX_KIND_212 = 8'h59;
  localparam logic [7:0] IDX_CTRL = 8'h7E;
  localparam logic [7:0] IDX_STATUS = 8'h7F;
  // Field positions and write masks
  localparam int FALL_HI = 7;
  localparam int FALL_LO = 4;
  localparam int RISE_HI = 3;
  localparam int RISE_LO = 0;
  localparam int DBL_BIT = 7;
  localparam int NUM_HI = 4;
  localparam logic [7:0] STYLE_MASK = 8'h77;
  localparam logic [7:0] LENGTH_MASK = 8'h9F;
  // Reset values
  localparam logic [7:0] STYLE_RST = 8'h00;
  localparam logic [7:0] LENGTH_RST = 8'h04;
  localparam logic [7:0] RESID_RST = 8'h00;
  localparam logic [7:0] KIND_RST = 8'h11;
  // Edge type codes
  localparam logic [3:0] KIND_LIN1 = 4'h1;
  localparam logic [3:0] KIND_LIN2 = 4'h2;
  localparam logic [3:0] KIND_LIN3 = 4'h3;
  localparam logic [3:0] KIND_LUT = 4'h4;
  localparam logic [3:0] KIND_LUT_ADJ_COR = 4'h5;
  localparam logic [3:0] KIND_LUT_ADJ = 4'h6;
  localparam logic [7:0] AMP_FULL = 8'hFF;
  // Carrier divider default: one carrier cycle per this many ref_clk cycles
  localparam logic [7:0] CARRIER_DIV_DEF = 8'h02;
  // Four edge tables of eight fractions each, entry 0 in the low byte
  localparam logic [255:0] EDGE_LUT = {
    64'hFFF0D8B080502810, 64'hFFF0E0C8A8886030,
    64'hFFD0A07850301808, 64'hFFE0C0A080604020};
  typedef enum logic [1:0] {ST_IDLE, ST_FALL, ST_LOW, ST_RISE} ces_state_e;
  typedef struct packed {
    logic [7:0] style;
    logic [7:0] length;
    logic [7:0] resid;
    logic [7:0] kind212;
    logic [7:0] kind106;
    logic prof;
    logic [3:0] lat_fk;
    logic [3:0] lat_rk;
    logic [2:0] lat_fs;
    logic [2:0] lat_rs;
    logic [4:0] lat_n;
    logic lat_dbl;
    logic [7:0] lat_resid;
    ces_state_e state;
    logic [4:0] step;
    logic sub;
    logic [7:0] div;
    logic [7:0] amp;
    logic busy;
    logic [7:0] vdd_s1;
    logic [7:0] vdd_s2;
    logic ack;
    logic wait_r;
    logic [31:0] rdata;
  } ces_s;
endpackage

// ### test/ces_edge_shaper_bench.sv
// Self-checking bench for the carrier edge shaper with a register and timing model
`timescale 1ns/1ps
`default_nettype none
module ces_edge_shaper_bench;
  localparam int DIV = 4;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [8:0] avs_address = 9'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic mod_pause = 1'b0;
  logic [7:0] amplifier_supply_voltage = 8'h80;
  logic [7:0] carrier_amp;
  logic shaping_busy;
  int n_fail = 0;
  int check_count = 0;
  logic [7:0] model [logic [7:0]];
  logic [31:0] rd;
  logic [7:0] res;
  logic [3:0] code;
  int nst, dbl, cnt, ex;

  ces_edge_shaper #(.CARRIER_DIV(8'(DIV))) ces_edge_shaper_inst (
    .ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mod_pause(mod_pause),
    .amplifier_supply_voltage(amplifier_supply_voltage), .carrier_amp(carrier_amp),
    .shaping_busy(shaping_busy));

  // Clock of 50 ns period
  always #25 ref_clk = ~ref_clk;

  // Compare one value and count it
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Print the counts and the verdict, then stop
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Bits that a write keeps; reserved bits read back zero
  function automatic logic [7:0] wmask(input logic [7:0] k);
    case (k)
      ces_pkg::IDX_STYLE_106: return ces_pkg::STYLE_MASK;
      ces_pkg::IDX_LENGTH_106: return ces_pkg::LENGTH_MASK;
      ces_pkg::IDX_CTRL: return 8'h01;
      default: return 8'hFF;
    endcase
  endfunction

  // One bus transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    int i;
    @(posedge ref_clk);
    avs_address <= {idx[6:0], 2'b00};
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'h000000, d};
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 20) begin
      n_fail++;
      summarize();
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // Register write that also updates the model
  task automatic wr(input logic [7:0] k, input logic [7:0] d);
    bus(1'b1, k, d);
    if (model.exists(k)) model[k] = d & wmask(k);
  endtask

  // Register read compared with the model
  task automatic rdchk(input logic [7:0] k);
    bus(1'b0, k, 8'h00);
    check(rd, {24'h000000, model.exists(k) ? model[k] : 8'h00});
  endtask

  // Wait for an amplitude and busy level, counting cycles
  task automatic wait_amp(input logic [7:0] a, input logic b, output int c);
    for (c = 1; c < 2000; c++) begin
      @(posedge ref_clk);
      if (carrier_amp === a && shaping_busy === b) break;
    end
    if (c == 2000) begin
      n_fail++;
      summarize();
    end
  endtask

  // Main sequence
  initial begin
    void'($urandom(79108));
    model[ces_pkg::IDX_KIND_106] = ces_pkg::KIND_RST;
    model[ces_pkg::IDX_STYLE_106] = ces_pkg::STYLE_RST;
    model[ces_pkg::IDX_LENGTH_106] = ces_pkg::LENGTH_RST;
    model[ces_pkg::IDX_RESID_212] = ces_pkg::RESID_RST;
    model[ces_pkg::IDX_KIND_212] = ces_pkg::KIND_RST;
    model[ces_pkg::IDX_CTRL] = 8'h00;
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    foreach (model[k]) rdchk(k);
    wr(8'h20, 8'hA5);
    rdchk(8'h20);
    // Write with byte 0 disabled is answered but ignored
    avs_byteenable <= 4'hE;
    bus(1'b1, ces_pkg::IDX_RESID_212, 8'h5A);
    avs_byteenable <= 4'hF;
    rdchk(ces_pkg::IDX_RESID_212);
    repeat (3) foreach (model[k]) begin
      wr(k, 8'($urandom));
      rdchk(k);
    end
    check({24'h0, carrier_amp}, {24'h0, ces_pkg::AMP_FULL});
    // Every edge type code on both edges, odd falling codes on profile 1 and even falling codes on profile 0
    for (int c = 1; c <= 6; c++) begin
      code = 4'(c);
      nst = 1 + $urandom % 8;
      dbl = $urandom % 2;
      res = 8'($urandom % 128);
      wr(ces_pkg::IDX_CTRL, 8'(c % 2));
      wr((c % 2) ? ces_pkg::IDX_KIND_212 : ces_pkg::IDX_KIND_106, {code, 4'(7 - c)});
      wr((c % 2) ? ces_pkg::IDX_KIND_106 : ces_pkg::IDX_KIND_212, 8'h11);
      wr(ces_pkg::IDX_STYLE_106, 8'($urandom) & 8'h77);
      wr(ces_pkg::IDX_LENGTH_106, {1'(dbl), 2'b00, 5'(nst)});
      wr(ces_pkg::IDX_RESID_212, res);
      amplifier_supply_voltage <= 8'($urandom);
      // The last falling state already shows the residual level
      ex = (nst - 1) * (dbl + 1) * DIV;
      @(posedge ref_clk);
      mod_pause <= 1'b1;
      wait_amp(res, 1'b1, cnt);
      check(32'(cnt >= ex - DIV + 3 && cnt <= ex + 2), 32'h1);
      wr(ces_pkg::IDX_RESID_212, res ^ 8'h80);
      // Let the last falling state run out before looking at the pause
      repeat (2 * DIV + 2) @(posedge ref_clk);
      bus(1'b0, ces_pkg::IDX_STATUS, 8'h00);
      check(rd, {8'h00, res, 3'h0, 5'(nst - 1), 6'h00, 2'h2});
      check({24'h0, carrier_amp}, {24'h0, res});
      mod_pause <= 1'b0;
      ex = nst * (dbl + 1) * DIV;
      wait_amp(ces_pkg::AMP_FULL, 1'b0, cnt);
      check(32'(cnt >= ex - DIV + 3 && cnt <= ex + 2), 32'h1);
    end
    summarize();
  end
endmodule
`default_nettype wire
